/* design/far_ops_pkg.sv */
package far_ops_pkg;
   localparam int DATA_W = 8;
   localparam int MSB_POS = 7;
   localparam int LSB_POS = 0;
   localparam logic [7:0] WORKING_RESET = 8'h00;
   localparam logic ZERO_FLAG_RESET = 1'b0;
   localparam logic CARRY_FLAG_RESET = 1'b0;

   typedef enum logic [3:0] {
      op_move_to_working,
      op_move_to_memory,
      op_or_to_working,
      op_or_to_memory,
      op_rotate_left,
      op_rotate_left_to_working,
      op_rotate_left_carry,
      op_rotate_left_carry_to_working,
      op_rotate_right,
      op_rotate_right_to_working,
      op_rotate_right_carry,
      op_rotate_right_carry_to_working
   } far_op_type;
endpackage : far_ops_pkg

/* design/far_rotator.sv */
module far_rotator
   import far_ops_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   input  wire logic [WIDTH-1:0] operand,
   input  wire logic             carry_in,
   input  wire logic             right,
   input  wire logic             through_carry,
   output logic      [WIDTH-1:0] result,
   output logic                  carry_out
);
   logic fill_bit;

   always_comb begin
      if (right) begin
         fill_bit  = through_carry ? carry_in : operand[0];
         result    = {fill_bit, operand[WIDTH-1:1]};
         carry_out = operand[0];
      end else begin
         fill_bit  = through_carry ? carry_in : operand[WIDTH-1];
         result    = {operand[WIDTH-2:0], fill_bit};
         carry_out = operand[WIDTH-1];
      end
   end
endmodule : far_rotator

/* design/far_ops_datapath.sv */
// Operation
// - Memory-to-working move loads working register, flags unchanged.
// - Working-to-memory move writes working register to memory, flags unchanged.
// - OR to working: working gets working OR memory, only zero updates.
// - OR to memory: memory gets working OR memory, only zero updates.
// - Rotate left in memory, bit 7 into bit 0, no flags.
// - Rotate left into working register, memory unchanged, no flags.
// - Rotate left through carry in memory; old bit 7 to carry.
// - Rotate left through carry into working; memory unchanged; carry updated.
// - Rotate right in memory, bit 0 into bit 7, no flags.
// - Rotate right into working register, memory unchanged, no flags.
// - Rotate right through carry in memory; old bit 0 to carry.
module far_ops_datapath
   import far_ops_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic             op_valid,
   input  far_op_type            op_code,
   input  wire logic [WIDTH-1:0] mem_rdata,
   output logic      [WIDTH-1:0] mem_wdata,
   output logic                  mem_we,
   output logic      [WIDTH-1:0] working_register,
   output logic                  zero_flag,
   output logic                  carry_flag
);
   logic [WIDTH-1:0] rot_result;
   logic             rot_carry;
   logic             rot_right;
   logic             rot_through;
   logic [WIDTH-1:0] or_result;
   logic [WIDTH-1:0] result_next;
   logic             to_working;
   logic             to_memory;
   logic             sets_zero;
   logic             sets_carry;
   logic             go;
   logic             result_zero;

   assign go          = op_valid && clk_en;
   assign result_zero = (result_next == '0);

   // One OR gate per bit
   for (genvar i = 0; i < WIDTH; i++) begin : g_or_bit
      assign or_result[i] = working_register[i] | mem_rdata[i];
   end

   far_rotator #(
      .WIDTH(WIDTH)
   ) u_rotator (
      .operand      (mem_rdata),
      .carry_in     (carry_flag),
      .right        (rot_right),
      .through_carry(rot_through),
      .result       (rot_result),
      .carry_out    (rot_carry)
   );

   // Rotator direction and carry insertion
   always_comb begin
      rot_right   = 1'b0;
      rot_through = 1'b0;
      case (op_code)
         op_rotate_left_carry: begin
            rot_through = 1'b1;
         end
         op_rotate_left_carry_to_working: begin
            rot_through = 1'b1;
         end
         op_rotate_right: begin
            rot_right = 1'b1;
         end
         op_rotate_right_to_working: begin
            rot_right = 1'b1;
         end
         op_rotate_right_carry: begin
            rot_right   = 1'b1;
            rot_through = 1'b1;
         end
         op_rotate_right_carry_to_working: begin
            rot_right   = 1'b1;
            rot_through = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // Destination per operation; unknown codes write nowhere
   always_comb begin
      case (op_code)
         op_move_to_working: begin
            to_working = 1'b1;
            to_memory  = 1'b0;
         end
         op_move_to_memory: begin
            to_working = 1'b0;
            to_memory  = 1'b1;
         end
         op_or_to_working: begin
            to_working = 1'b1;
            to_memory  = 1'b0;
         end
         op_or_to_memory: begin
            to_working = 1'b0;
            to_memory  = 1'b1;
         end
         op_rotate_left: begin
            to_working = 1'b0;
            to_memory  = 1'b1;
         end
         op_rotate_left_to_working: begin
            to_working = 1'b1;
            to_memory  = 1'b0;
         end
         op_rotate_left_carry: begin
            to_working = 1'b0;
            to_memory  = 1'b1;
         end
         op_rotate_left_carry_to_working: begin
            to_working = 1'b1;
            to_memory  = 1'b0;
         end
         op_rotate_right: begin
            to_working = 1'b0;
            to_memory  = 1'b1;
         end
         op_rotate_right_to_working: begin
            to_working = 1'b1;
            to_memory  = 1'b0;
         end
         op_rotate_right_carry: begin
            to_working = 1'b0;
            to_memory  = 1'b1;
         end
         op_rotate_right_carry_to_working: begin
            to_working = 1'b1;
            to_memory  = 1'b0;
         end
         default: begin
            to_working = 1'b0;
            to_memory  = 1'b0;
         end
      endcase
   end

   // Flag effects; moves and plain rotates touch no flag
   always_comb begin
      sets_zero  = 1'b0;
      sets_carry = 1'b0;
      case (op_code)
         op_or_to_working: begin
            sets_zero = 1'b1;
         end
         op_or_to_memory: begin
            sets_zero = 1'b1;
         end
         op_rotate_left_carry: begin
            sets_carry = 1'b1;
         end
         op_rotate_left_carry_to_working: begin
            sets_carry = 1'b1;
         end
         op_rotate_right_carry: begin
            sets_carry = 1'b1;
         end
         op_rotate_right_carry_to_working: begin
            sets_carry = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // Result source
   always_comb begin
      case (op_code)
         op_move_to_working: begin
            result_next = mem_rdata;
         end
         op_move_to_memory: begin
            result_next = working_register;
         end
         op_or_to_working,
         op_or_to_memory: begin
            result_next = or_result;
         end
         default: begin
            result_next = rot_result;
         end
      endcase
   end

   // Memory write enable is registered, never a glitch; mem_we holds its value while clk_en is low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mem_we    <= 1'b0;
         mem_wdata <= WORKING_RESET;
      end else if (clk_en) begin
         mem_we <= op_valid && to_memory;
         // Write data holds between writes so memory never sees a stray value
         if (op_valid && to_memory) begin
            mem_wdata <= result_next;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         working_register <= WORKING_RESET;
      end else if (go && to_working) begin
         working_register <= result_next;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         zero_flag <= ZERO_FLAG_RESET;
      end else if (go && sets_zero) begin
         zero_flag <= result_zero;
      end
   end

   // Carry only moves on through-carry rotates; old carry was already sampled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         carry_flag <= CARRY_FLAG_RESET;
      end else if (go && sets_carry) begin
         carry_flag <= rot_carry;
      end
   end
endmodule : far_ops_datapath

/* sim/far_ops_checker.sv */
module far_ops_checker
   import far_ops_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       clk_en,
   input wire logic       op_valid,
   input far_op_type      op_code,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] mem_wdata,
   input wire logic       mem_we,
   input wire logic [7:0] working_register,
   input wire logic       zero_flag,
   input wire logic       carry_flag
);
   timeunit 1ns / 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire [3:0] oc = (op_valid && clk_en) ? op_code : 4'hf;
   chk_move_load: assert property (oc == op_move_to_working |=>
      working_register == $past(mem_rdata) && $stable(zero_flag)) else $error("load");
   chk_move_store: assert property (oc == op_move_to_memory |=>
      mem_we && mem_wdata == $past(working_register)) else $error("store");
   chk_or_zero: assert property (oc == op_or_to_working |=>
      zero_flag == (working_register == 8'h00)) else $error("or zero");
   chk_or_mem: assert property (oc == op_or_to_memory |=>
      mem_wdata == ($past(working_register) | $past(mem_rdata))) else $error("or mem");
   chk_rol_mem: assert property (oc == op_rotate_left |=>
      {mem_wdata[0], mem_wdata[7:1]} == $past(mem_rdata)) else $error("rol");
   chk_rlc_mem: assert property (oc == op_rotate_left_carry |=>
      {carry_flag, mem_wdata} == {$past(mem_rdata), $past(carry_flag)}) else $error("rlc");
   chk_ror_mem: assert property (oc == op_rotate_right |=>
      {mem_wdata[6:0], mem_wdata[7]} == $past(mem_rdata)) else $error("ror");
   chk_rrc_mem: assert property (oc == op_rotate_right_carry |=>
      {mem_wdata, carry_flag} == {$past(carry_flag), $past(mem_rdata)}) else $error("rrc");
   chk_freeze_hold: assert property (!clk_en |=> $stable(working_register) &&
      $stable(zero_flag) && $stable(carry_flag) && $stable(mem_we)) else $error("freeze");
endmodule : far_ops_checker

/* sim/far_mem_model.sv */
module far_mem_model (
   input  wire logic       ref_clk,
   input  wire logic       mem_we,
   input  wire logic [7:0] mem_wdata,
   input  wire logic       preload,
   input  wire logic [7:0] preload_data,
   output logic      [7:0] mem_rdata = 8'h00
);
   timeunit 1ns / 1ps;
   // Byte holds between writes, so stale data shows
   always @(posedge ref_clk) begin
      if (preload) begin
         mem_rdata <= preload_data;
      end else if (mem_we) begin
         mem_rdata <= mem_wdata;
      end
   end
endmodule : far_mem_model

/* sim/far_ops_datapath_tb_top.sv */
module far_ops_datapath_tb_top
   import far_ops_pkg::*;
();
   timeunit 1ns / 1ps;
   logic       ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, op_valid = 1'b0;
   logic       mem_we, zero_flag, carry_flag;
   logic [7:0] mem_rdata, mem_wdata, working_register;
   logic       preload = 1'b0;
   logic [7:0] preload_data = 8'h00;
   far_op_type op_code = op_move_to_working;
   int         bad_count = 0, n_checks = 0, cyc = 0;
   wire [17:0] seen = {mem_rdata, working_register, zero_flag, carry_flag};
   far_ops_datapath DUT (.*);
   far_mem_model MEM (.*);
   initial forever #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (++cyc == 300) results();
   task automatic results();
      if (cyc >= 300) bad_count++;
      $display("%0d checks %0d errors", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   task automatic step(far_op_type o, logic [15:0] mw, logic [1:0] f);
      @(posedge ref_clk);
      op_code <= o;
      op_valid <= 1'b1;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      n_checks++;
      if (seen !== {mw, f}) begin
         bad_count++;
         $display("Error state exp %h got %h", {mw, f}, seen);
      end
   endtask : step
   task automatic move_or_ops();
      step(op_or_to_working, 16'h0000, 2'b10);
      @(posedge ref_clk);
      preload_data <= 8'h81;
      preload <= 1'b1;
      @(posedge ref_clk);
      preload <= 1'b0;
      step(op_rotate_left_carry, 16'h0200, 2'b11);
      step(op_move_to_working, 16'h0202, 2'b11);
      step(op_rotate_left_carry_to_working, 16'h0205, 2'b10);
      step(op_or_to_memory, 16'h0705, 2'b00);
      step(op_move_to_memory, 16'h0505, 2'b00);
   endtask : move_or_ops
   task automatic rotate_ops();
      step(op_rotate_right_carry, 16'h0205, 2'b01);
      step(op_rotate_right, 16'h0105, 2'b01);
      step(op_rotate_left_to_working, 16'h0102, 2'b01);
      step(op_rotate_left, 16'h0202, 2'b01);
      step(op_rotate_right_to_working, 16'h0201, 2'b01);
      step(op_rotate_right_carry, 16'h8101, 2'b00);
      step(op_rotate_right_carry_to_working, 16'h8140, 2'b01);
   endtask : rotate_ops
   task automatic freeze_op();
      @(posedge ref_clk);
      clk_en <= 1'b0;
      op_code <= op_rotate_left_carry_to_working;
      op_valid <= 1'b1;
      @(posedge ref_clk);
      clk_en <= 1'b1;
      op_valid <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      n_checks++;
      if ({mem_we, seen} !== {1'b0, 16'h8140, 2'b01}) begin
         bad_count++;
         $display("Error freeze exp %h got %h", {1'b0, 16'h8140, 2'b01}, {mem_we, seen});
      end
   endtask : freeze_op
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      move_or_ops();
      rotate_ops();
      freeze_op();
      results();
   end
endmodule : far_ops_datapath_tb_top
bind far_ops_datapath far_ops_checker chk_i (.*);
